// File: pkg/bscfm_pkg.sv
/*
  bscfm_pkg: constants shared by the slot configuration and fault monitor.
  assumes a 100 MHz core clock and an axi4-lite register bus of 32-bit words.
*/
package bscfm_pkg;
  // address decode
  localparam logic [23:0] BSCFM_BASE_MULT   = 24'h000040;
  localparam logic [23:0] BSCFM_BASE_OFFSET = 24'h00c000;
  localparam int          BSCFM_LA_MIN      = 1;
  // interrupt level selector
  localparam logic [3:0]  BSCFM_LVL_MAX     = 4'h7;
  // register offsets
  localparam logic [7:0]  BSCFM_OFF_CONFIG  = 8'h00;
  localparam logic [7:0]  BSCFM_OFF_CTRL    = 8'h04;
  localparam logic [7:0]  BSCFM_OFF_STATUS  = 8'h08;
  localparam logic [7:0]  BSCFM_OFF_IRQ_ST  = 8'h0c;
  localparam logic [7:0]  BSCFM_OFF_IRQ_MSK = 8'h10;
  localparam logic [7:0]  BSCFM_OFF_TRIG    = 8'h14;
  localparam logic [7:0]  BSCFM_OFF_SLV_ID  = 8'h18;
  localparam logic [7:0]  BSCFM_OFF_EVENT   = 8'h1c;
  // ctrl register fields
  localparam int          BSCFM_CTRL_TEST   = 0;
  localparam int          BSCFM_CTRL_PASS   = 1;
  localparam int          BSCFM_CTRL_FAIL   = 2;
  localparam int          BSCFM_CTRL_FAST   = 3;
  // interrupt status bit positions
  localparam int          BSCFM_EV_FUSE     = 0;
  localparam int          BSCFM_EV_TRIG     = 1;
  localparam int          BSCFM_EV_TEST     = 2;
  localparam int          BSCFM_EV_ID       = 3;
  localparam int          BSCFM_EV_PROTO    = 4;
  localparam int          BSCFM_NEV         = 5;
  // reset values
  localparam logic [31:0] BSCFM_RST_WORD    = 32'h00000000;
  localparam logic [1:0]  BSCFM_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  BSCFM_RESP_SLVERR = 2'b10;
  // serial id shift rate
  localparam int          BSCFM_CLK_HZ      = 100_000_000;
  localparam int          BSCFM_SER_HZ      = 1_000_000;
  localparam int          BSCFM_SER_DIV     = BSCFM_CLK_HZ / BSCFM_SER_HZ;
  localparam int          BSCFM_ID_BITS     = 8;

  typedef enum logic [1:0] {
    BSCFM_ST_TEST,
    BSCFM_ST_PASSED,
    BSCFM_ST_FAILED
  } bscfm_state_type;
endpackage

// File: rtl/bscfm_id_shift.sv
/*
  bscfm_id_shift: reads an identification word from each slave over one
  serial input line, one slave after another, clocked by an enable pulse.
  assumes the slave presents msb first on each enable, selected by slave_sel.
*/
`timescale 1ns/1ns
module bscfm_id_shift
  import bscfm_pkg::*;
#(
  parameter int N_SLAVES = 12,
  parameter int SEL_W    = 4
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // control
  input  wire logic                     start,
  input  wire logic                     bit_en,
  input  wire logic                     ser_in,
  // results
  output logic      [SEL_W-1:0]         slave_sel,
  output logic                          busy,
  output logic                          done,
  output logic      [N_SLAVES*BSCFM_ID_BITS-1:0] ids
);
  logic [SEL_W-1:0]                    sel_r,  sel_nxt;
  logic [3:0]                          bit_r,  bit_nxt;
  logic                                busy_r, busy_nxt;
  logic                                done_r, done_nxt;
  logic [N_SLAVES*BSCFM_ID_BITS-1:0]   ids_r,  ids_nxt;

  always_comb begin
    sel_nxt  = sel_r;
    bit_nxt  = bit_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    ids_nxt  = ids_r;
    if (!busy_r && start) begin
      busy_nxt = 1'b1;
      sel_nxt  = '0;
      bit_nxt  = '0;
    end else if (busy_r && bit_en) begin
      ids_nxt[int'(sel_r)*BSCFM_ID_BITS + (BSCFM_ID_BITS-1-int'(bit_r))] = ser_in;
      if (bit_r == 4'(BSCFM_ID_BITS-1)) begin
        bit_nxt = '0;
        if (sel_r == SEL_W'(N_SLAVES-1)) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          sel_nxt = sel_r + 1'b1;
        end
      end else begin
        bit_nxt = bit_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r  <= '0;
      bit_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ids_r  <= '0;
    end else begin
      sel_r  <= sel_nxt;
      bit_r  <= bit_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      ids_r  <= ids_nxt;
    end
  end

  assign slave_sel = sel_r;
  assign busy      = busy_r;
  assign done      = done_r;
  assign ids       = ids_r;
endmodule // bscfm_id_shift

// File: rtl/bscfm_top.sv
/*
  bscfm_top: backplane slot configuration and fault monitor with an axi4-lite
  register slave. holds the decoded address, interrupt level, fuse watch,
  trigger lines, self test state and slave identification reader.
  assumes switches, fuses, triggers and serial input are synchronous to core_clk;
  the firmware reports self test results through the ctrl register.
*/
// Behaviour
// RULE1 - the logical address 1..ff is built from the high and low switch digits.
// RULE2 - the base address is the logical address times 40 hex plus c000 hex.
// RULE3 - the high switch gives the upper hex digit and the low switch the lower.
// RULE4 - a selector of one to seven requests interrupts on that backplane level.
// RULE5 - a selector of zero or eight produces no backplane interrupt request.
// RULE6 - selector settings nine to f are treated as interrupts disabled.
// RULE7 - backplane interrupts carry protocol events to the commander.
// RULE8 - any open slave supply fuse asserts the system-fail line.
// RULE9 - on command one selected of eight trigger lines is driven.
// RULE10 - on command any subset of the eight trigger lines is monitored.
// RULE11 - word serial transfers with the fast handshake are accepted.
// RULE12 - a serial input reads an identification from each slave.
// RULE13 - self tests run at power-on and on command.
// RULE14 - the fault indicator is lit exactly while in the failed state.
// RULE15 - after the interface test the fail line is released on pass and held on fail.
// RULE16 - switches are sampled at reset and held stable afterwards.
`timescale 1ns/1ns
module bscfm_top
  import bscfm_pkg::*;
#(
  parameter int N_SLAVES = 12,
  parameter int N_TRIG   = 8
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // configuration switches
  input  wire logic [3:0]           addr_switch_high_digit,
  input  wire logic [3:0]           addr_switch_low_digit,
  input  wire logic [3:0]           irq_level_switch,
  // axi4-lite write address
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // decoded configuration
  output logic [23:0]               base_addr,
  output logic [2:0]                irq_level,
  output logic                      fast_handshake_en,
  // backplane interrupt and system fail
  input  wire logic                 proto_event,
  output logic [7:1]                vme_irq_req_b,
  output logic                      sysfail_b,
  // fuses and front panel
  input  wire logic [N_SLAVES-1:0]  fuse_open,
  output logic                      failed_led,
  // trigger lines, open drain
  input  wire logic [N_TRIG-1:0]    trig_in,
  output logic [N_TRIG-1:0]         trig_out,
  output logic [N_TRIG-1:0]         trig_oe_b,
  // slave identification serial input
  input  wire logic                 id_ser_in,
  output logic [3:0]                id_slave_sel,
  // interrupt to local processor
  output logic                      irq
);
  // configuration captured once after reset release
  logic        cfg_done_r, cfg_done_nxt;
  logic [7:0]  la_r, la_nxt;
  logic [3:0]  sel_r, sel_nxt;
  // control and status state
  bscfm_state_type st_r, st_nxt;
  logic        fast_r, fast_nxt;
  logic [BSCFM_NEV-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic [2:0]  drv_sel_r, drv_sel_nxt;
  logic        drv_en_r, drv_en_nxt;
  logic [N_TRIG-1:0] mon_r, mon_nxt, trig_q_r, trig_q_nxt;
  logic [6:0]  div_r, div_nxt;
  // axi state
  logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  // internal
  logic        wr_go, rd_go, lvl_ok, fuse_any, bit_en, id_start, id_busy, id_done;
  logic        trig_hit, test_cmd;
  logic [N_SLAVES*BSCFM_ID_BITS-1:0] ids;
  logic [BSCFM_NEV-1:0] ev;
  logic [31:0] rmux;
  logic        rerr;

  bscfm_id_shift #(
    .N_SLAVES (N_SLAVES),
    .SEL_W    (4)
  ) u_id (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .start     (id_start),
    .bit_en    (bit_en),
    .ser_in    (id_ser_in),
    .slave_sel (id_slave_sel),
    .busy      (id_busy),
    .done      (id_done),
    .ids       (ids)
  );

  assign wr_go    = aw_r && w_r && !bv_r;
  assign rd_go    = s_axi_arvalid && !rv_r;
  assign lvl_ok   = (sel_r != 4'h0) && (sel_r <= BSCFM_LVL_MAX); // see RULE4 see RULE5 see RULE6
  assign fuse_any = |fuse_open;
  assign bit_en   = (div_r == 7'(BSCFM_SER_DIV-1));
  assign trig_hit = |(trig_in & mon_r & ~trig_q_r); // see RULE10
  assign test_cmd = wr_go && (awa_r == BSCFM_OFF_CTRL) && wd_r[BSCFM_CTRL_TEST];
  // power-on read runs on the capture cycle; a command while busy is ignored
  assign id_start = test_cmd || !cfg_done_r; // see RULE12 see RULE13

  always_comb begin
    ev = '0;
    ev[BSCFM_EV_FUSE]  = fuse_any;
    ev[BSCFM_EV_TRIG]  = trig_hit;
    ev[BSCFM_EV_TEST]  = (st_r == BSCFM_ST_TEST) && (st_nxt != BSCFM_ST_TEST);
    ev[BSCFM_EV_ID]    = id_done;
    ev[BSCFM_EV_PROTO] = proto_event; // see RULE7
  end

  always_comb begin
    rmux = BSCFM_RST_WORD;
    rerr = 1'b0;
    unique case (s_axi_araddr)
      BSCFM_OFF_CONFIG:  rmux = {4'h0, sel_r, base_addr[15:0], la_r};
      BSCFM_OFF_CTRL:    rmux = {28'h0, fast_r, 3'h0};
      BSCFM_OFF_STATUS:  rmux = {26'h0, id_busy, fuse_any, 2'h0, st_r};
      BSCFM_OFF_IRQ_ST:  rmux = {27'h0, ist_r};
      BSCFM_OFF_IRQ_MSK: rmux = {27'h0, imsk_r};
      BSCFM_OFF_TRIG:    rmux = {8'h0, trig_in, mon_r, 3'h0, drv_en_r, 1'b0, drv_sel_r};
      BSCFM_OFF_SLV_ID:  rmux = 32'(ids[BSCFM_ID_BITS*4-1:0]);
      BSCFM_OFF_EVENT:   rmux = 32'(fuse_open);
      default:           rerr = 1'b1;
    endcase
  end

  always_comb begin
    cfg_done_nxt = 1'b1;
    la_nxt   = la_r;
    sel_nxt  = sel_r;
    if (!cfg_done_r) begin
      la_nxt  = {addr_switch_high_digit, addr_switch_low_digit}; // see RULE1 see RULE3 see RULE16
      sel_nxt = irq_level_switch; // see RULE16
    end
    st_nxt   = st_r;
    fast_nxt = fast_r;
    imsk_nxt = imsk_r;
    drv_sel_nxt = drv_sel_r;
    drv_en_nxt  = drv_en_r;
    mon_nxt  = mon_r;
    trig_q_nxt = trig_in;
    div_nxt  = bit_en ? '0 : div_r + 7'h01;
    ist_nxt  = ist_r;
    aw_nxt = aw_r;  awa_nxt = awa_r;
    w_nxt  = w_r;   wd_nxt  = wd_r;
    bv_nxt = bv_r;  br_nxt  = br_r;
    rv_nxt = rv_r;  rd_nxt  = rd_r;  rr_nxt = rr_r;
    if (s_axi_awvalid && !aw_r) begin
      aw_nxt  = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r) begin
      w_nxt  = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = BSCFM_RESP_OKAY;
      unique case (awa_r)
        BSCFM_OFF_CTRL: begin
          fast_nxt = wd_r[BSCFM_CTRL_FAST]; // see RULE11
          if (wd_r[BSCFM_CTRL_TEST]) st_nxt = BSCFM_ST_TEST; // see RULE13
          else if (st_r == BSCFM_ST_TEST && wd_r[BSCFM_CTRL_PASS])
            st_nxt = BSCFM_ST_PASSED; // see RULE15
          else if (st_r == BSCFM_ST_TEST && wd_r[BSCFM_CTRL_FAIL])
            st_nxt = BSCFM_ST_FAILED; // see RULE15
        end
        BSCFM_OFF_IRQ_ST:  ist_nxt = ist_r & ~wd_r[BSCFM_NEV-1:0];
        BSCFM_OFF_IRQ_MSK: imsk_nxt = wd_r[BSCFM_NEV-1:0];
        BSCFM_OFF_TRIG: begin
          drv_sel_nxt = wd_r[2:0]; // see RULE9
          drv_en_nxt  = wd_r[4];
          mon_nxt     = wd_r[15:8]; // see RULE10
        end
        BSCFM_OFF_CONFIG, BSCFM_OFF_STATUS, BSCFM_OFF_SLV_ID, BSCFM_OFF_EVENT: ;
        default: br_nxt = BSCFM_RESP_SLVERR;
      endcase
    end
    ist_nxt = ist_nxt | ev; // set wins over a same-cycle clear
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (rd_go) begin
      rv_nxt = 1'b1;
      rd_nxt = rmux;
      rr_nxt = rerr ? BSCFM_RESP_SLVERR : BSCFM_RESP_OKAY;
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_done_r <= 1'b0;
      la_r       <= 8'h01;
      sel_r      <= 4'h0;
      st_r       <= BSCFM_ST_TEST; // power-on test
      fast_r     <= 1'b0;
      ist_r      <= '0;
      imsk_r     <= '0;
      drv_sel_r  <= 3'h0;
      drv_en_r   <= 1'b0;
      mon_r      <= '0;
      trig_q_r   <= '1; // idle level of the pulled-up lines, no false edge
      div_r      <= 7'h00;
      aw_r <= 1'b0;  awa_r <= 8'h00;
      w_r  <= 1'b0;  wd_r  <= 32'h00000000;
      bv_r <= 1'b0;  br_r  <= 2'b00;
      rv_r <= 1'b0;  rd_r  <= 32'h00000000;  rr_r <= 2'b00;
    end else begin
      cfg_done_r <= cfg_done_nxt;
      la_r       <= la_nxt;
      sel_r      <= sel_nxt;
      st_r       <= st_nxt;
      fast_r     <= fast_nxt;
      ist_r      <= ist_nxt;
      imsk_r     <= imsk_nxt;
      drv_sel_r  <= drv_sel_nxt;
      drv_en_r   <= drv_en_nxt;
      mon_r      <= mon_nxt;
      trig_q_r   <= trig_q_nxt;
      div_r      <= div_nxt;
      aw_r <= aw_nxt;  awa_r <= awa_nxt;
      w_r  <= w_nxt;   wd_r  <= wd_nxt;
      bv_r <= bv_nxt;  br_r  <= br_nxt;
      rv_r <= rv_nxt;  rd_r  <= rd_nxt;  rr_r <= rr_nxt;
    end
  end

  // a zero address switch setting is illegal; clamp to the lowest legal value
  assign base_addr = 24'(24'((la_r == 8'h00 ? 8'(BSCFM_LA_MIN) : la_r) * BSCFM_BASE_MULT)
                     + BSCFM_BASE_OFFSET); // see RULE1 see RULE2
  assign irq_level = lvl_ok ? sel_r[2:0] : 3'h0;
  assign fast_handshake_en = fast_r; // see RULE11

  genvar g;
  generate
    for (g = 1; g <= 7; g++) begin : g_lvl
      assign vme_irq_req_b[g] = !(lvl_ok && irq && sel_r[2:0] == 3'(g)); // see RULE4 see RULE7
    end
    for (g = 0; g < N_TRIG; g++) begin : g_trig
      assign trig_out[g]  = 1'b0;
      assign trig_oe_b[g] = !(drv_en_r && drv_sel_r == 3'(g)); // see RULE9
    end
  endgenerate

  // fail line stays low during the test and whenever a fuse is open
  assign sysfail_b  = !(fuse_any || st_r != BSCFM_ST_PASSED); // see RULE8 see RULE15
  assign failed_led = (st_r == BSCFM_ST_FAILED); // see RULE14
  assign irq        = |(ist_r & imsk_r);

  assign s_axi_awready = !aw_r;
  assign s_axi_wready  = !w_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
endmodule // bscfm_top

// File: sim/bscfm_chk.sv
/* checker for the slot monitor: watches top-level ports only.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ns
module bscfm_chk
  import bscfm_pkg::*;
#(
  parameter int N_SLAVES = 12,
  parameter int N_TRIG   = 8
) (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // configuration
  input wire logic [23:0]         base_addr,
  input wire logic [2:0]          irq_level,
  // backplane
  input wire logic [7:1]          vme_irq_req_b,
  input wire logic                sysfail_b,
  input wire logic                irq,
  input wire logic [N_SLAVES-1:0] fuse_open,
  input wire logic                failed_led,
  input wire logic [N_TRIG-1:0]   trig_oe_b
);
  logic [2:0] up_cnt_r;
  logic [2:0] up_cnt_nxt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // switches are captured after release, so judge the decode once it has settled
  always_comb up_cnt_nxt = (up_cnt_r == 3'h7) ? up_cnt_r : up_cnt_r + 3'h1;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) up_cnt_r <= 3'h0;
    else up_cnt_r <= up_cnt_nxt;
  end

  a_lvl_off_quiet: assert property (irq_level == 3'h0 |-> &vme_irq_req_b)
    else $error("interrupt request driven while disabled");
  a_lvl_one_line: assert property (irq && irq_level != 3'h0 |->
    !vme_irq_req_b[irq_level] && $countones(vme_irq_req_b) == 6)
    else $error("interrupt request not on the selected level");
  a_no_irq_quiet: assert property (!irq |-> &vme_irq_req_b)
    else $error("interrupt request without a pending event");
  a_fuse_sysfail: assert property (|fuse_open |-> !sysfail_b)
    else $error("open fuse without system fail");
  a_fail_holds: assert property (failed_led |-> !sysfail_b)
    else $error("failed state released system fail");
  a_base_align: assert property (up_cnt_r == 3'h7 |-> base_addr[5:0] == 6'h0
    && base_addr >= 24'h00c040 && base_addr <= 24'h00ffc0)
    else $error("base address outside the decoded window");
  a_cfg_steady: assert property (up_cnt_r == 3'h7 |-> $stable(base_addr) && $stable(irq_level))
    else $error("configuration moved after capture");
  a_trig_one_drv: assert property ($countones(~trig_oe_b) <= 1)
    else $error("more than one trigger line driven");
endmodule // bscfm_chk

bind bscfm_top bscfm_chk #(.N_SLAVES(N_SLAVES), .N_TRIG(N_TRIG)) chk_u (.core_clk, .rst_b,
  .base_addr, .irq_level, .vme_irq_req_b, .sysfail_b, .irq, .fuse_open, .failed_led,
  .trig_oe_b);

// File: sim/bscfm_cmdr_model.sv
/* commander side model: protocol events, pulled-up trigger wires, slave ids.
   assumes the bench raises ev_req and ext_low right after a clock edge. */
`timescale 1ns/1ns
module bscfm_cmdr_model (
  // clock
  input  wire logic       core_clk,
  // bench requests
  input  wire logic       ev_req,
  input  wire logic [7:0] ext_low,
  // device side
  input  wire logic [7:0] trig_out,
  input  wire logic [7:0] trig_oe_b,
  input  wire logic [3:0] id_slave_sel,
  output logic            proto_event,
  output logic [7:0]      trig_in,
  output logic            id_ser_in
);
  logic ev_d;
  always_ff @(posedge core_clk) ev_d <= ev_req;
  // one-cycle event per request edge
  assign proto_event = ev_req && !ev_d;
  // open-drain wires with pull-up: any driver low wins
  assign trig_in = ~(ext_low | (~trig_oe_b & ~trig_out));
  // odd slaves answer all ones, even slaves all zeros
  assign id_ser_in = id_slave_sel[0];
endmodule // bscfm_cmdr_model

// File: sim/test_backplane_slot_config_and_fault_monitor.sv
/* testbench: axi4-lite tasks walk the slot monitor through its behaviour.
   assumes the commander model supplies events, trigger wires and ids. */
`timescale 1ns/1ns
module test_backplane_slot_config_and_fault_monitor;
  import bscfm_pkg::*;
  logic core_clk, rst_b, ev_req, proto_event, id_ser_in, irq, sysfail_b, failed_led;
  logic fast_handshake_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  addr_switch_high_digit, addr_switch_low_digit, irq_level_switch;
  logic [3:0]  s_axi_wstrb, id_slave_sel, sel;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, trig_in, trig_out, trig_oe_b, ext_low, la;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] base_addr, eb;
  logic [2:0]  irq_level, el;
  logic [7:1]  vme_irq_req_b;
  logic [6:0]  ev;
  logic [11:0] fuse_open;
  logic [11:0] cfg [6] = '{12'h0a3, 12'h158, 12'h019, 12'h0bc, 12'h010, 12'hff7};
  int          n_mismatch, checks_done, n;

  bscfm_top dut_u (.core_clk, .rst_b, .addr_switch_high_digit, .addr_switch_low_digit,
    .irq_level_switch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .base_addr, .irq_level, .fast_handshake_en, .proto_event, .vme_irq_req_b,
    .sysfail_b, .fuse_open, .failed_led, .trig_in, .trig_out, .trig_oe_b, .id_ser_in,
    .id_slave_sel, .irq);
  bscfm_cmdr_model cmdr_u (.core_clk, .ev_req, .ext_low, .trig_out, .trig_oe_b,
    .id_slave_sel, .proto_event, .trig_in, .id_ser_in);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready; tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid; r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tk;
    logic [31:0] d;
    logic [1:0] r;
    tk = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!tk) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready; tk = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) s_axi_rready <= 1'b0;
    end
    chk(d & m, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic do_reset(input logic [11:0] c);
    @(posedge core_clk);
    {addr_switch_high_digit, addr_switch_low_digit, irq_level_switch} <= c;
    rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic pulse_low(input logic [7:0] p);
    @(posedge core_clk); ext_low <= p;
    repeat (2) @(posedge core_clk); ext_low <= 8'h00;
    repeat (3) @(posedge core_clk); @(negedge core_clk);
  endtask

  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0; ev_req = 1'b0; ext_low = 8'h00; fuse_open = 12'h000; s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
    {addr_switch_high_digit, addr_switch_low_digit, irq_level_switch} = 12'h0;
    for (int i = 0; i < 6; i++) begin
      do_reset(cfg[i]);
      la = cfg[i][11:4]; sel = cfg[i][3:0];
      eb = 24'(la) * BSCFM_BASE_MULT + BSCFM_BASE_OFFSET;
      el = (sel >= 4'h1 && sel <= 4'h7) ? sel[2:0] : 3'h0;
      ev = (el == 3'h0) ? 7'h7f : ~(7'h01 << (el - 3'h1));
      @(negedge core_clk);
      chk(32'(base_addr), 32'(eb));
      chk(32'(irq_level), 32'(el));
      chk(32'(sysfail_b), 32'h0);
      rd(BSCFM_OFF_CONFIG, 32'hffffffff, {4'h0, sel, eb[15:0], la}, BSCFM_RESP_OKAY);
      {addr_switch_high_digit, addr_switch_low_digit, irq_level_switch} <= ~cfg[i];
      wr(BSCFM_OFF_CTRL, 32'h2, BSCFM_RESP_OKAY);
      wr(BSCFM_OFF_IRQ_MSK, 32'h10, BSCFM_RESP_OKAY);
      ev_req <= 1'b1;
      @(posedge core_clk); ev_req <= 1'b0;
      repeat (2) @(posedge core_clk); @(negedge core_clk);
      chk(32'(base_addr), 32'(eb));
      chk(32'(sysfail_b), 32'h1);
      chk(32'(irq), 32'h1);
      chk(32'(vme_irq_req_b), 32'(ev));
      wr(BSCFM_OFF_IRQ_ST, 32'h10, BSCFM_RESP_OKAY);
      @(negedge core_clk);
      chk(32'(vme_irq_req_b), 32'h7f);
    end
    wr(BSCFM_OFF_IRQ_MSK, 32'h01, BSCFM_RESP_OKAY);
    fuse_open <= 12'h800;
    repeat (3) @(posedge core_clk); @(negedge core_clk);
    chk(32'(sysfail_b), 32'h0);
    chk(32'(vme_irq_req_b), 32'h3f);
    fuse_open <= 12'h000;
    wr(BSCFM_OFF_IRQ_ST, 32'h1f, BSCFM_RESP_OKAY);
    @(negedge core_clk);
    chk({30'h0, irq, sysfail_b}, 32'h1);
    wr(BSCFM_OFF_CTRL, 32'h1, BSCFM_RESP_OKAY);
    rd(BSCFM_OFF_STATUS, 32'h3, 32'h0, BSCFM_RESP_OKAY);
    wr(BSCFM_OFF_CTRL, 32'h4, BSCFM_RESP_OKAY);
    @(negedge core_clk);
    chk({failed_led, sysfail_b}, 32'h2);
    rd(BSCFM_OFF_STATUS, 32'h3, 32'h2, BSCFM_RESP_OKAY);
    wr(BSCFM_OFF_CTRL, 32'h1, BSCFM_RESP_OKAY);
    @(negedge core_clk);
    chk({failed_led, sysfail_b}, 32'h0);
    wr(BSCFM_OFF_CTRL, 32'ha, BSCFM_RESP_OKAY);
    @(negedge core_clk);
    chk({fast_handshake_en, failed_led, sysfail_b}, 32'h5);
    rd(BSCFM_OFF_CTRL, 32'h8, 32'h8, BSCFM_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(BSCFM_OFF_TRIG, 32'h10 | i, BSCFM_RESP_OKAY);
      @(negedge core_clk);
      chk(32'(trig_oe_b), 32'hff & ~(32'h1 << i));
      rd(BSCFM_OFF_TRIG, 32'hff0000, {8'h0, ~(8'h01 << i), 16'h0}, BSCFM_RESP_OKAY);
    end
    wr(BSCFM_OFF_TRIG, 32'h2000, BSCFM_RESP_OKAY);
    wr(BSCFM_OFF_IRQ_ST, 32'h1f, BSCFM_RESP_OKAY);
    wr(BSCFM_OFF_IRQ_MSK, 32'h02, BSCFM_RESP_OKAY);
    @(negedge core_clk);
    chk(32'(trig_oe_b), 32'hff);
    pulse_low(8'h04);
    chk(32'(irq), 32'h0);
    pulse_low(8'h20);
    chk(32'(irq), 32'h1);
    wr(8'h40, 32'h1, BSCFM_RESP_SLVERR);
    rd(8'h40, 32'hffffffff, 32'h0, BSCFM_RESP_SLVERR);
    wr(BSCFM_OFF_IRQ_MSK, 32'h08, BSCFM_RESP_OKAY);
    wr(BSCFM_OFF_IRQ_ST, 32'h1f, BSCFM_RESP_OKAY);
    for (n = 0; n < 15000 && irq !== 1'b1; n++) @(negedge core_clk);
    chk(32'(irq), 32'h1);
    rd(BSCFM_OFF_SLV_ID, 32'hffffffff, 32'hff00ff00, BSCFM_RESP_OKAY);
    give_verdict();
  end
endmodule // test_backplane_slot_config_and_fault_monitor
